// *** sim/obc_option_bank_tb_top.sv ***
// Self-checking testbench of the option byte bank
`timescale 1ns/1ps
`include "obc_cfg.svh"
module obc_option_bank_tb_top;
  import obc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, cold_cfg_en, port2_converter_trigger_off;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, cfg_loaded, ers;
  logic [4:0] cfg_integrity_err, err;
  logic [5:0] runtime_port0_mux;
  logic [1:0] wake_clock_divider_sel, wakeup_clock_source, read_delay_cycles;
  logic [1:0] port0_pins01_select, port0_pins23_select, port0_pins45_select;
  logic [9:0] wake_divide_x2;
  logic [12:0] settle_half_cycles;
  logic [7:0] crystal_settle_count;
  logic external_clock_type, osc_out_enable, wake_use_external, pwm_engine_adc_trigger_en;
  logic converter_hw_trigger_en, pwm_open_drain_disable, basic_timer_zero_off;
  logic basic_timer_one_off, converter_mode_flush_off, converter_autoreload_off;
  logic converter_autoflush_off, converter_legacy_abort;
  int num_errors, checked, seed, nlow;
  // Model: stored bytes and applied config bytes
  logic [7:0] st [11];
  logic [7:0] ap [5];
  logic [7:0] fac [11] = '{8'hd7, 8'h89, 8'h76, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff,
    8'h00, 8'hff};
  logic [7:0] msk [5] = '{8'hbf, 8'hff, 8'h70, 8'h57, 8'h3f};
  logic [7:0] codes [4] = '{8'h00, 8'hb4, 8'hd2, 8'he1};

  obc_option_bank obc_option_bank_i (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [19:0] adr(input int i);
    return 20'((`OBC_IDX_BASE + i) * 4);
  endfunction : adr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t ns: got %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    // Answer taken at the very edge where pready was sampled high
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    ers = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input int i, input logic [31:0] exp);
    apb(1'b0, adr(i), 8'h00);
    chk(ers, 1'b0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_loaded();
    nlow = 0;
    repeat (40) begin
      @(negedge clk);
      if (cfg_loaded === 1'b1) break;
      nlow++;
    end
  endtask : wait_loaded

  task automatic model_load();
    err = '0;
    for (int p = 0; p < 5; p++) begin
      if (st[2*p+1] === ~st[2*p+2]) begin
        ap[p] = st[2*p+1];
      end else begin
        ap[p] = fac[2*p+1];
        err[p] = 1'b1;
      end
    end
  endtask : model_load

  task automatic chk_out();
    logic [7:0] c, s;
    logic [5:0] pm;
    @(negedge clk);
    c = ap[0];
    s = ap[1];
    pm = cold_cfg_en ? ap[4][5:0] : runtime_port0_mux;
    chk(wake_clock_divider_sel, c[1:0]);
    chk(wake_divide_x2, c[1:0] == 0 ? 375 : c[1:0] == 1 ? 250 : c[1:0] == 2 ? 125 : 62);
    chk({external_clock_type, osc_out_enable}, {c[3], ~c[3]});
    chk({wakeup_clock_source, wake_use_external}, {c[4], c[2], {c[4], c[2]} == 2'b01});
    chk({pwm_engine_adc_trigger_en, converter_hw_trigger_en},
      {c[5] & ~port2_converter_trigger_off, ~port2_converter_trigger_off});
    chk(pwm_open_drain_disable, c[7]);
    chk({crystal_settle_count, 3'h0, settle_half_cycles},
      {s, 3'h0, s == 8'hb4 ? 13'd256 : s == 8'hd2 ? 13'd16 : s == 8'he1 ? 13'd1 : 13'd4096});
    chk({basic_timer_one_off, converter_mode_flush_off, basic_timer_zero_off}, ap[2][6:4]);
    chk(read_delay_cycles, ap[3][1:0]);
    chk({converter_legacy_abort, converter_autoflush_off, converter_autoreload_off},
      {ap[3][6], ap[3][4], ap[3][2]});
    chk({port0_pins45_select, port0_pins23_select, port0_pins01_select}, pm);
    chk(cfg_integrity_err, err);
  endtask : chk_out

  task automatic regs_chk();
    for (int i = 0; i < 11; i++) rdchk(i, {24'h0, st[i]});
    rdchk(19, {23'h0, 1'b1, 3'h0, err});
  endtask : regs_chk

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    st = fac;
    model_load();
    wait_loaded();
    chk(nlow, 5);
    chk_out();
    regs_chk();
    $display("reset test done");
  endtask : do_reset

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Whole run needs well under 10000 cycles
  initial begin
    #(50 * 20000);
    num_errors++;
    conclude();
  end

  initial begin
    logic [7:0] v;
    seed = 81713;
    {rst_n, psel, penable, pwrite, cold_cfg_en, port2_converter_trigger_off} = '0;
    paddr = '0;
    pwdata = '0;
    runtime_port0_mux = '0;
    do_reset();
    apb(1'b1, adr(11), 8'h5a);
    chk(ers, 1'b1);
    apb(1'b0, adr(11), 8'h00);
    chk({ers, rd}, {1'b1, 32'h0});
    apb(1'b0, adr(2) | 20'h1, 8'h00);
    chk(ers, 1'b1);
    rdchk(18, 32'h0);
    $display("refusal test done");
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 5; p++) begin
        v = 8'($random(seed)) & msk[p];
        if (p == 0) v[1:0] = 2'(k);
        if (p == 1 && k < 4) v = codes[k];
        st[2*p+1] = v;
        // Later passes break one pair each
        st[2*p+2] = (k >= 3 && p == k - 3) ? ~v ^ 8'h10 : ~v;
        apb(1'b1, adr(2*p+1), st[2*p+1]);
        apb(1'b1, adr(2*p+2), st[2*p+2]);
      end
      @(posedge clk);
      cold_cfg_en <= 1'($random(seed));
      port2_converter_trigger_off <= 1'($random(seed));
      runtime_port0_mux <= 6'($random(seed));
      chk_out();
      regs_chk();
      apb(1'b1, adr(18), 8'h01);
      model_load();
      wait_loaded();
      chk(nlow, 5);
      chk_out();
      $display("reload pass %0d done", k);
    end
    do_reset();
    conclude();
  end
endmodule : obc_option_bank_tb_top

// *** src/obc_cfg.svh ***
// Constants of the option byte configuration bank
// Function
// - Each configuration byte is followed by a byte holding its exact bitwise inverse.
// - Two-bit prescale picks 24, 16, 8 or 4 MHz input divided to 128 kHz.
// - Clock type bit 3: 0 crystal on both pins, 1 direct clock on input pin.
// - Wakeup clock code 00 low-speed internal, 01 prescaled external, others reserved.
// - Clock byte bit 5 enables engine converter trigger; needs port 2 trigger option 0.
// - Clock byte bit 7 at 0 enables pseudo open-drain on PWM outputs.
// - Settle count 0x00, 0xb4, 0xd2, 0xe1 give 2048, 128, 8, 0.5 cycles.
// - Feature bit 4 at 0 enables basic timer zero, 1 disables it.
// - Feature bit 5 at 0 enables converter mode flush, 1 disables it.
// - Feature bit 6 at 0 enables basic timer one, 1 disables it.
// - Wait field adds zero to three delay cycles on memory reads.
// - Wait byte bit 2 at 0 enables converter auto-reload command.
// - Wait byte bit 4 at 0 enables converter auto-flush command.
// - Wait byte bit 6 at 1 selects the legacy abort and flush sequence.
// - Port 0 option byte holds three two-bit pin-pair selects in bits 5 to 0.
// - Cold configuration takes pin muxing from option bytes, else from runtime registers.
// - Option values reach their consumers during the loader phase after reset release.
// - Port 2 trigger option at 0 enables converter hardware trigger.
`ifndef OBC_CFG_SVH
`define OBC_CFG_SVH
// Register indices; byte address is four times the index
`define OBC_IDX_BASE 20'h04806
`define OBC_IDX_MISC_INV 20'h04806
`define OBC_IDX_CLK 20'h04807
`define OBC_IDX_CLK_INV 20'h04808
`define OBC_IDX_STAB 20'h04809
`define OBC_IDX_STAB_INV 20'h0480a
`define OBC_IDX_FEAT 20'h0480b
`define OBC_IDX_FEAT_INV 20'h0480c
`define OBC_IDX_WAIT 20'h0480d
`define OBC_IDX_WAIT_INV 20'h0480e
`define OBC_IDX_P0 20'h0480f
`define OBC_IDX_P0_INV 20'h04810
`define OBC_IDX_CTRL 20'h04818
`define OBC_IDX_STAT 20'h04819
`define OBC_NUM_BYTES 11
`define OBC_NUM_PAIRS 5
// Factory values, in index order from the base
`define OBC_RST_MISC_INV 8'hd7
`define OBC_RST_CLK 8'h89
`define OBC_RST_CLK_INV 8'h76
`define OBC_RST_STAB 8'h00
`define OBC_RST_STAB_INV 8'hff
`define OBC_RST_FEAT 8'h00
`define OBC_RST_FEAT_INV 8'hff
`define OBC_RST_WAIT 8'h00
`define OBC_RST_WAIT_INV 8'hff
`define OBC_RST_P0 8'h00
`define OBC_RST_P0_INV 8'hff
// Field positions
`define OBC_CLK_OD_BIT 7
`define OBC_CLK_TRIG_BIT 5
`define OBC_CLK_AWU1_BIT 4
`define OBC_CLK_EXT_BIT 3
`define OBC_CLK_AWU0_BIT 2
`define OBC_FEAT_TIM0_BIT 4
`define OBC_FEAT_MFLUSH_BIT 5
`define OBC_FEAT_TIM1_BIT 6
`define OBC_WAIT_ARLOD_BIT 2
`define OBC_WAIT_AFLUSH_BIT 4
`define OBC_WAIT_NABT_BIT 6
`define OBC_CTRL_RELOAD_BIT 0
`define OBC_STAT_LOADED_BIT 8
// Wake clock figures
`define OBC_WAKE_KHZ 128
`define OBC_PRSC0_MHZ 24
`define OBC_PRSC1_MHZ 16
`define OBC_PRSC2_MHZ 8
`define OBC_PRSC3_MHZ 4
// Settle codes and their lengths in half cycles
`define OBC_SETTLE_C0 8'h00
`define OBC_SETTLE_C1 8'hb4
`define OBC_SETTLE_C2 8'hd2
`define OBC_SETTLE_C3 8'he1
`define OBC_SETTLE_H0 13'h1000
`define OBC_SETTLE_H1 13'h0100
`define OBC_SETTLE_H2 13'h0010
`define OBC_SETTLE_H3 13'h0001
`endif

// *** src/obc_option_bank.sv ***
// Option byte bank with APB access, complement check loader and decoded options
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "obc_cfg.svh"
module obc_option_bank #(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Same-clock system inputs
  input wire logic cold_cfg_en,
  input wire logic port2_converter_trigger_off,
  input wire logic [5:0] runtime_port0_mux,
  // Loader status
  output logic cfg_loaded,
  output logic [4:0] cfg_integrity_err,
  // Clock options
  output logic [1:0] wake_clock_divider_sel,
  output logic [9:0] wake_divide_x2,
  output logic external_clock_type,
  output logic osc_out_enable,
  output logic [1:0] wakeup_clock_source,
  output logic wake_use_external,
  output logic pwm_engine_adc_trigger_en,
  output logic converter_hw_trigger_en,
  output logic pwm_open_drain_disable,
  // Oscillator settle
  output logic [7:0] crystal_settle_count,
  output logic [12:0] settle_half_cycles,
  // Feature and wait options
  output logic basic_timer_zero_off,
  output logic basic_timer_one_off,
  output logic converter_mode_flush_off,
  output logic [1:0] read_delay_cycles,
  output logic converter_autoreload_off,
  output logic converter_autoflush_off,
  output logic converter_legacy_abort,
  // Port 0 pin muxing
  output logic [1:0] port0_pins01_select,
  output logic [1:0] port0_pins23_select,
  output logic [1:0] port0_pins45_select
);
  import obc_pkg::*;

  // Byte index needs 15 bits after the two low address bits
  if (ADDR_W < 17 || ADDR_W > 32) begin : g_bad_addr
    $error("obc_option_bank: ADDR_W must lie in 17..32");
  end

  localparam obc_byte_t FACTORY [`OBC_NUM_BYTES] = '{
    `OBC_RST_MISC_INV, `OBC_RST_CLK, `OBC_RST_CLK_INV, `OBC_RST_STAB,
    `OBC_RST_STAB_INV, `OBC_RST_FEAT, `OBC_RST_FEAT_INV, `OBC_RST_WAIT,
    `OBC_RST_WAIT_INV, `OBC_RST_P0, `OBC_RST_P0_INV};
  localparam logic [19:0] IDX_LAST = `OBC_IDX_P0_INV;
  localparam obc_pair_t LAST_PAIR = 3'(`OBC_NUM_PAIRS - 1);

  obc_byte_t store_reg [`OBC_NUM_BYTES];
  obc_byte_t applied_reg [`OBC_NUM_PAIRS];
  logic [4:0] err_reg;
  obc_state_t state_reg;
  obc_pair_t pair_reg;
  logic [31:0] prdata_reg;

  logic [19:0] idx;
  logic aligned;
  logic hit_store;
  logic hit_ctrl;
  logic hit_stat;
  logic mapped;
  logic [3:0] store_sel;
  logic wr_fire;
  logic reload_req;
  logic [31:0] rd_mux;
  obc_byte_t ld_cfg;
  obc_byte_t ld_inv;
  logic ld_bad;

  // Address decode
  assign idx = 20'(paddr[ADDR_W-1:2]);
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_store = aligned && idx >= `OBC_IDX_BASE && idx <= IDX_LAST;
  assign hit_ctrl = aligned && idx == `OBC_IDX_CTRL;
  assign hit_stat = aligned && idx == `OBC_IDX_STAT;
  assign mapped = hit_store || hit_ctrl || hit_stat;
  assign store_sel = 4'(idx - `OBC_IDX_BASE);

  // Access waits out the loader so a reload never races a write
  assign pready = (state_reg == OBC_ST_RUN);
  assign pslverr = psel && penable && pready && !mapped;
  assign wr_fire = psel && penable && pready && pwrite && mapped;
  assign reload_req = wr_fire && hit_ctrl && pwdata[`OBC_CTRL_RELOAD_BIT];
  assign prdata = prdata_reg;

  always_comb begin
    rd_mux = 32'h0;
    if (hit_store) begin
      rd_mux = {24'h0, store_reg[store_sel]};
    end else if (hit_stat) begin
      rd_mux[4:0] = err_reg;
      rd_mux[`OBC_STAT_LOADED_BIT] = cfg_loaded;
    end
  end

  // Read data held in a flop, refreshed every selected read cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0;
    end else if (psel && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // Option byte store; reset brings back the factory image
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      store_reg <= FACTORY;
    end else if (wr_fire && hit_store) begin
      store_reg[store_sel] <= pwdata[7:0];
    end
  end

  // Loader walks the five pairs, one per cycle
  assign ld_cfg = store_reg[2*pair_reg+1];
  assign ld_inv = store_reg[2*pair_reg+2];
  assign ld_bad = (ld_cfg != ~ld_inv);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= OBC_ST_LOAD;
      pair_reg <= 3'h0;
    end else if (state_reg == OBC_ST_LOAD) begin
      pair_reg <= (pair_reg == LAST_PAIR) ? 3'h0 : pair_reg + 3'h1;
      if (pair_reg == LAST_PAIR) begin
        state_reg <= OBC_ST_RUN;
      end
    end else if (reload_req) begin
      state_reg <= OBC_ST_LOAD;
      pair_reg <= 3'h0;
    end
  end

  // Corrupt pair falls back to its factory byte instead of a half-broken value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `OBC_NUM_PAIRS; i++) begin
        applied_reg[i] <= FACTORY[2*i+1];
      end
      err_reg <= 5'h0;
    end else if (state_reg == OBC_ST_LOAD) begin
      applied_reg[pair_reg] <= ld_bad ? FACTORY[2*pair_reg+1] : ld_cfg;
      err_reg[pair_reg] <= ld_bad;
    end
  end

  assign cfg_loaded = (state_reg == OBC_ST_RUN);
  assign cfg_integrity_err = err_reg;

  // Clock configuration decode
  assign wake_clock_divider_sel = applied_reg[0][1:0];
  always_comb begin
    unique case (wake_clock_divider_sel)
      2'h0: wake_divide_x2 = 10'(2 * `OBC_PRSC0_MHZ * 1000 / `OBC_WAKE_KHZ);
      2'h1: wake_divide_x2 = 10'(2 * `OBC_PRSC1_MHZ * 1000 / `OBC_WAKE_KHZ);
      2'h2: wake_divide_x2 = 10'(2 * `OBC_PRSC2_MHZ * 1000 / `OBC_WAKE_KHZ);
      2'h3: wake_divide_x2 = 10'(2 * `OBC_PRSC3_MHZ * 1000 / `OBC_WAKE_KHZ);
    endcase
  end
  assign external_clock_type = applied_reg[0][`OBC_CLK_EXT_BIT];
  assign osc_out_enable = !external_clock_type;
  assign wakeup_clock_source = {applied_reg[0][`OBC_CLK_AWU1_BIT],
                                applied_reg[0][`OBC_CLK_AWU0_BIT]};
  // Reserved codes fall back to the internal oscillator
  assign wake_use_external = (wakeup_clock_source == 2'h1);
  assign converter_hw_trigger_en = !port2_converter_trigger_off;
  assign pwm_engine_adc_trigger_en = applied_reg[0][`OBC_CLK_TRIG_BIT]
                                     && !port2_converter_trigger_off;
  assign pwm_open_drain_disable = applied_reg[0][`OBC_CLK_OD_BIT];

  // Oscillator settle decode; unknown codes take the longest wait
  assign crystal_settle_count = applied_reg[1];
  always_comb begin
    if (crystal_settle_count == `OBC_SETTLE_C1) begin
      settle_half_cycles = `OBC_SETTLE_H1;
    end else if (crystal_settle_count == `OBC_SETTLE_C2) begin
      settle_half_cycles = `OBC_SETTLE_H2;
    end else if (crystal_settle_count == `OBC_SETTLE_C3) begin
      settle_half_cycles = `OBC_SETTLE_H3;
    end else begin
      settle_half_cycles = `OBC_SETTLE_H0;
    end
  end

  // Feature and wait decode
  assign basic_timer_zero_off = applied_reg[2][`OBC_FEAT_TIM0_BIT];
  assign converter_mode_flush_off = applied_reg[2][`OBC_FEAT_MFLUSH_BIT];
  assign basic_timer_one_off = applied_reg[2][`OBC_FEAT_TIM1_BIT];
  assign read_delay_cycles = applied_reg[3][1:0];
  assign converter_autoreload_off = applied_reg[3][`OBC_WAIT_ARLOD_BIT];
  assign converter_autoflush_off = applied_reg[3][`OBC_WAIT_AFLUSH_BIT];
  assign converter_legacy_abort = applied_reg[3][`OBC_WAIT_NABT_BIT];

  // Port 0 muxing source
  always_comb begin
    if (cold_cfg_en) begin
      {port0_pins45_select, port0_pins23_select, port0_pins01_select} =
        applied_reg[4][5:0];
    end else begin
      {port0_pins45_select, port0_pins23_select, port0_pins01_select} =
        runtime_port0_mux;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PAIR_FLAG: assert property (
    state_reg == OBC_ST_LOAD |=> err_reg[$past(pair_reg)] == $past(ld_bad))
    else $error("Integrity flag does not follow pair compare");
  AST_FALLBACK: assert property (
    (state_reg == OBC_ST_LOAD && ld_bad && pair_reg == 3'h1) |=> applied_reg[1] == `OBC_RST_STAB)
    else $error("Corrupt settle pair not replaced by factory byte");
  AST_LOAD_LEN: assert property (
    (state_reg == OBC_ST_LOAD && pair_reg == 3'h0) |-> !cfg_loaded [*5] ##1 cfg_loaded)
    else $error("Loader phase not five cycles");
  AST_ENGINE_TRIG: assert property (
    pwm_engine_adc_trigger_en |-> !port2_converter_trigger_off && applied_reg[0][5])
    else $error("Engine trigger enabled against port 2 option");
  AST_RUNTIME_MUX: assert property (
    !cold_cfg_en |-> {port0_pins45_select, port0_pins23_select, port0_pins01_select}
                      == runtime_port0_mux)
    else $error("Warm config does not follow runtime mux");
  AST_SETTLE: assert property (
    crystal_settle_count == 8'hb4 |-> settle_half_cycles == 13'h0100)
    else $error("Settle count 0xb4 not 128 cycles");
  AST_WAKE_DIV: assert property (
    wake_clock_divider_sel == 2'h1 |-> wake_divide_x2 == 10'd250)
    else $error("16 MHz prescale not divide by 125");
  AST_OSC_PINS: assert property (
    external_clock_type != osc_out_enable)
    else $error("Oscillator output drive wrong for clock type");
  AST_WAIT_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[3] |-> read_delay_cycles == store_reg[7][1:0])
    else $error("Wait states not taken from store");
  AST_STALL: assert property (
    reload_req |=> !pready [*5] ##1 pready)
    else $error("Reload does not stall bus for five cycles");

  // Loader cycle count, kept beside the pair index as a cross-check
  logic [2:0] ld_cycles_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ld_cycles_reg <= 3'h0;
    end else if (state_reg == OBC_ST_LOAD) begin
      ld_cycles_reg <= ld_cycles_reg + 3'h1;
    end else begin
      ld_cycles_reg <= 3'h0;
    end
  end

  AST_LOAD_STEP: assert property (
    state_reg == OBC_ST_LOAD |-> ld_cycles_reg == pair_reg)
    else $error("Loader skipped or repeated a pair");
  AST_LOAD_BOUND: assert property (
    ld_cycles_reg <= 3'(`OBC_NUM_PAIRS))
    else $error("Loader phase ran past the last pair");
  AST_ERR_CLK: assert property (
    $rose(cfg_loaded) |-> err_reg[0] == (store_reg[1] != ~store_reg[2]))
    else $error("Clock pair flag disagrees with stored bytes");
  AST_ERR_P0: assert property (
    $rose(cfg_loaded) |-> err_reg[4] == (store_reg[9] != ~store_reg[10]))
    else $error("Port 0 pair flag disagrees with stored bytes");
  AST_ERR_HOLD: assert property (
    cfg_loaded && !reload_req |=> $stable(err_reg))
    else $error("Integrity flags moved outside a loader pass");
  AST_HOLD_RUN: assert property (
    cfg_loaded |=> $stable(read_delay_cycles) && $stable(crystal_settle_count))
    else $error("Applied options changed outside a loader pass");

  // Each option follows its stored byte when the pair is sound
  AST_WAKE_CLOCK_DIVIDER_SEL_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[0] |-> wake_clock_divider_sel == store_reg[1][1:0])
    else $error("Prescale select not taken from store");
  AST_EXT_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[0] |-> external_clock_type == store_reg[1][`OBC_CLK_EXT_BIT])
    else $error("Clock type not taken from store");
  AST_AWU_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[0] |-> wakeup_clock_source ==
      {store_reg[1][`OBC_CLK_AWU1_BIT], store_reg[1][`OBC_CLK_AWU0_BIT]})
    else $error("Wakeup clock source not taken from split bits");
  AST_OD_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[0] |-> pwm_open_drain_disable == store_reg[1][`OBC_CLK_OD_BIT])
    else $error("Open drain option not taken from store");
  AST_STAB_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[1] |-> crystal_settle_count == store_reg[3])
    else $error("Settle count not taken from store");
  AST_TIM0_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[2] |-> basic_timer_zero_off == store_reg[5][`OBC_FEAT_TIM0_BIT])
    else $error("Timer zero option not taken from store");
  AST_MFLUSH_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[2] |->
      converter_mode_flush_off == store_reg[5][`OBC_FEAT_MFLUSH_BIT])
    else $error("Mode flush option not taken from store");
  AST_TIM1_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[2] |-> basic_timer_one_off == store_reg[5][`OBC_FEAT_TIM1_BIT])
    else $error("Timer one option not taken from store");
  AST_ARLOD_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[3] |->
      converter_autoreload_off == store_reg[7][`OBC_WAIT_ARLOD_BIT])
    else $error("Auto-reload option not taken from store");
  AST_AFLUSH_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[3] |->
      converter_autoflush_off == store_reg[7][`OBC_WAIT_AFLUSH_BIT])
    else $error("Auto-flush option not taken from store");
  AST_NABT_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[3] |-> converter_legacy_abort == store_reg[7][`OBC_WAIT_NABT_BIT])
    else $error("Abort mode option not taken from store");
  AST_P0_LOAD: assert property (
    $rose(cfg_loaded) && !err_reg[4] && cold_cfg_en |->
      {port0_pins45_select, port0_pins23_select, port0_pins01_select} == store_reg[9][5:0])
    else $error("Cold port 0 selects not taken from store");

  // A broken pair must show the factory value, never the stored one
  AST_CLK_FALLBACK: assert property (
    $rose(cfg_loaded) && err_reg[0] |-> applied_reg[0] == `OBC_RST_CLK)
    else $error("Corrupt clock pair not replaced by factory byte");
  AST_WAIT_FALLBACK: assert property (
    $rose(cfg_loaded) && err_reg[3] |-> read_delay_cycles == 2'(`OBC_RST_WAIT))
    else $error("Corrupt wait pair not replaced by factory byte");
  AST_P0_FALLBACK: assert property (
    $rose(cfg_loaded) && err_reg[4] && cold_cfg_en |->
      {port0_pins45_select, port0_pins23_select, port0_pins01_select} == 6'(`OBC_RST_P0))
    else $error("Corrupt port 0 pair not replaced by factory byte");
  AST_TRIG_OFF: assert property (
    port2_converter_trigger_off |-> !converter_hw_trigger_en && !pwm_engine_adc_trigger_en)
    else $error("Converter trigger left on against port 2 option");

  COV_RELOAD: cover property (reload_req ##6 cfg_loaded);
  COV_CORRUPT: cover property (state_reg == OBC_ST_LOAD && ld_bad);
  COV_COLD: cover property (cold_cfg_en && cfg_loaded);
  COV_BADADDR: cover property (pslverr);
  COV_BAD_PORT0: cover property ($rose(cfg_loaded) && err_reg[4]);
endmodule : obc_option_bank

// *** src/obc_pkg.sv ***
// Types of the option byte configuration bank
package obc_pkg;
  typedef enum logic [0:0] {OBC_ST_LOAD, OBC_ST_RUN} obc_state_t;
  typedef logic [2:0] obc_pair_t;
  typedef logic [7:0] obc_byte_t;
endpackage : obc_pkg
